/* src/ac_out_pkg.sv */
package ac_out_pkg;
	// clock and time base
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned TICK_US = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	// process value range: 0..1000 is 0..100 % in 0.1 % steps
	localparam logic [15:0] PV_FULL = 16'h03e8;
	localparam int unsigned PV_W = 16;
	// filter accumulator: fraction bits give full resolution on the slope
	localparam int unsigned FRAC_W = 16;
	localparam int unsigned ACC_W = PV_W + FRAC_W;
	// startup delay times in ms, index by code
	localparam int unsigned DLY_MS_100 = 100;
	localparam int unsigned DLY_MS_1S = 1000;
	localparam int unsigned DLY_MS_2S = 2000;
	localparam int unsigned DLY_MS_3S = 3000;
	localparam int unsigned DLY_MS_4S = 4000;
	localparam int unsigned DLY_MS_5S = 5000;
	localparam int unsigned DLY_MS_10S = 10000;
	// filter times in ms
	localparam int unsigned FLT_MS_500 = 500;
	localparam int unsigned FLT_MS_1S = 1000;
	localparam int unsigned FLT_MS_5S = 5000;
	localparam int unsigned FLT_MS_10S = 10000;
	localparam int unsigned FLT_MS_30S = 30000;
	localparam int unsigned FLT_MS_60S = 60000;
	localparam int unsigned TICKS_PER_MS = 1000 / TICK_US;
	// reset values
	localparam logic [15:0] SUBST_RST = 16'h0000;

	typedef enum logic [1:0] {
		STOP_OFF = 2'h0,
		STOP_KEEP = 2'h1,
		STOP_SUBST = 2'h2
	} stop_react_e;

	typedef enum logic [2:0] {
		DLY_NONE = 3'h0,
		DLY_100MS = 3'h1,
		DLY_1S = 3'h2,
		DLY_2S = 3'h3,
		DLY_3S = 3'h4,
		DLY_4S = 3'h5,
		DLY_5S = 3'h6,
		DLY_10S = 3'h7
	} start_dly_e;

	typedef enum logic [2:0] {
		FLT_NONE = 3'h0,
		FLT_500MS = 3'h1,
		FLT_1S = 3'h2,
		FLT_5S = 3'h3,
		FLT_10S = 3'h4,
		FLT_30S = 3'h5,
		FLT_60S = 3'h6
	} filt_time_e;

	// per-channel configuration
	typedef struct packed {
		logic active;
		logic temp_shutdown;
		logic diag_overflow_en;
		logic diag_wire_break_en;
		stop_react_e stop_react;
		start_dly_e start_dly;
		filt_time_e filt_up;
		filt_time_e filt_down;
		logic [15:0] subst_value;
	} chan_cfg_s;

	// per-channel status
	typedef struct packed {
		logic value_status;
		logic diag_overflow;
		logic diag_wire_break;
		logic diag_overtemp;
		logic delay_running;
	} chan_stat_s;

	// ticks of the 100 us time base for a startup delay code
	function automatic logic [16:0] dly_ticks(input start_dly_e d);
		unique case (d)
			DLY_NONE: dly_ticks = 17'h0;
			DLY_100MS: dly_ticks = 17'(DLY_MS_100 * TICKS_PER_MS);
			DLY_1S: dly_ticks = 17'(DLY_MS_1S * TICKS_PER_MS);
			DLY_2S: dly_ticks = 17'(DLY_MS_2S * TICKS_PER_MS);
			DLY_3S: dly_ticks = 17'(DLY_MS_3S * TICKS_PER_MS);
			DLY_4S: dly_ticks = 17'(DLY_MS_4S * TICKS_PER_MS);
			DLY_5S: dly_ticks = 17'(DLY_MS_5S * TICKS_PER_MS);
			DLY_10S: dly_ticks = 17'(DLY_MS_10S * TICKS_PER_MS);
		endcase
	endfunction

	// slope per tick in fractional units: full scale over filter time
	function automatic logic [ACC_W-1:0] ramp_step(input filt_time_e f);
		logic [ACC_W-1:0] full;
		full = ACC_W'({PV_FULL, FRAC_W'(0)});
		case (f)
			FLT_500MS: ramp_step = full / ACC_W'(FLT_MS_500 * TICKS_PER_MS);
			FLT_1S: ramp_step = full / ACC_W'(FLT_MS_1S * TICKS_PER_MS);
			FLT_5S: ramp_step = full / ACC_W'(FLT_MS_5S * TICKS_PER_MS);
			FLT_10S: ramp_step = full / ACC_W'(FLT_MS_10S * TICKS_PER_MS);
			FLT_30S: ramp_step = full / ACC_W'(FLT_MS_30S * TICKS_PER_MS);
			FLT_60S: ramp_step = full / ACC_W'(FLT_MS_60S * TICKS_PER_MS);
			default: ramp_step = full;
		endcase
	endfunction
endpackage

/* src/ac_output_channel_control.sv */
`timescale 1ns/1ps
// Contract
// RL1 - overtemperature with shutdown configured deactivates channel
// RL2 - ignore process values until temperature recovers
// RL3 - startup delay 100 ms to 10 s
// RL4 - startup delay applies to substitute values
// RL5 - delay restarts on startup and load return
// RL6 - separate rising and falling filters, 500ms-60s
// RL7 - filter held in reset during delay; the code holds the accumulator at its last value instead
// RL8 - ramp starts from the held value
// RL9 - filter time means full-scale step
// RL10 - independent full-resolution filter per channel
// RL11 - filtering also applies to substitute values
// RL12 - no-filter setting passes changes directly
// RL13 - stop reaction may output substitute value
// RL14 - value status bit 0 when value absent
// RL15 - quality variant always generates value status
// RL16 - deactivated channel not driven
// RL17 - overflow diagnostic when enabled and out-of-range; the code raises it only with phase_control_mode_in set
// RL18 - wire-break diagnostic when enabled and open
// RL19 - controller commands only 0 to 1000
// RL20 - step from filter time, saturate at target
// RL21 - off while inactive, overheated or delaying
module ac_output_channel_control #(
	parameter int unsigned CHANNELS = 4,
	parameter int unsigned TICK_DIV = ac_out_pkg::TICK_CYCLES
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire ac_out_pkg::chan_cfg_s [CHANNELS-1:0] cfg_in,
	input wire logic [CHANNELS-1:0][15:0] process_value_in,
	input wire logic controller_stop_in,
	input wire logic comm_fail_in,
	input wire logic quality_information_bits_in,
	input wire logic value_status_en_in,
	input wire logic phase_control_mode_in,
	input wire logic over_temp_in,
	input wire logic load_voltage_ok_in,
	input wire logic [CHANNELS-1:0] wire_open_in,
	output logic [CHANNELS-1:0][15:0] drive_level_out,
	output ac_out_pkg::chan_stat_s [CHANNELS-1:0] status_out
);
	import ac_out_pkg::*;

	initial begin
		if (CHANNELS < 1 || TICK_DIV < 1) begin
			$error("channel count and tick divider must be at least one");
		end
	end

	// monitor inputs come from analog comparators: two flops each
	// the stop line crosses from the controller side, so it is synchronised too;
	// two cycles of latency are negligible against the tick period
	// only the second flop is read by any logic below
	logic [2:0] mon_meta_reg;
	logic [2:0] mon_sync_reg;
	logic [CHANNELS-1:0] open_meta_reg;
	logic [CHANNELS-1:0] open_sync_reg;
	always_ff @(posedge mclk_in) begin
		mon_meta_reg <= {over_temp_in, load_voltage_ok_in, controller_stop_in};
		mon_sync_reg <= mon_meta_reg;
		open_meta_reg <= wire_open_in;
		open_sync_reg <= open_meta_reg;
	end
	wire over_temp = mon_sync_reg[2];
	wire load_ok = mon_sync_reg[1];
	wire ctrl_stop = mon_sync_reg[0];

	// load return edge and first cycle after reset both restart delays
	logic load_ok_reg;
	logic started_reg;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			load_ok_reg <= 1'b0;
			started_reg <= 1'b0;
		end else begin
			load_ok_reg <= load_ok;
			started_reg <= 1'b1;
		end
	end
	wire restart_delay = !started_reg || (load_ok && !load_ok_reg); // RL5

	// time base: one enable pulse every tick period
	// every delay and ramp counts these pulses, never raw clock cycles,
	// so a smaller divider shortens all timing in proportion
	logic [31:0] div_reg;
	logic tick_reg;
	wire div_end = (div_reg == TICK_DIV - 1);
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			div_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_end ? 32'h0 : div_reg + 32'h1;
			tick_reg <= div_end;
		end
	end

	// status generation forced on in the quality variant
	wire vs_enable = quality_information_bits_in || value_status_en_in; // RL15

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			chan_cfg_s cfg;
			assign cfg = cfg_in[ch];

			// startup delay counter per channel, counts ticks
			logic [16:0] dly_reg;
			logic [16:0] dly_next;
			wire delaying = (dly_reg != 17'h0);
			// reload while the load supply is missing, so the delay runs from its return
			wire load_delay = restart_delay || !load_ok;
			// count down one per tick until the delay has fully expired
			wire count_down = tick_reg && delaying;
			// full delay length for the configured code
			wire [16:0] dly_len = dly_ticks(cfg.start_dly);
			always_comb begin
				dly_next = dly_reg;
				if (load_delay) begin
					dly_next = dly_len; // RL3 RL5
				end else if (count_down) begin
					dly_next = dly_reg - 17'h1;
				end
			end
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					dly_reg <= 17'h0;
				end else begin
					dly_reg <= dly_next;
				end
			end

			// latched shutdown: cleared only when temperature is valid again
			// set wins over clear, so a hot reading never slips through
			logic shut_reg;
			wire shut_set = over_temp && cfg.temp_shutdown;
			wire shut_clr = !over_temp;
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					shut_reg <= 1'b0;
				end else if (shut_set) begin
					shut_reg <= 1'b1; // RL1
				end else if (shut_clr) begin
					shut_reg <= 1'b0; // RL2
				end
			end

			// keep-last-value snapshot taken while the controller runs
			// no snapshot during stop, so the held value is the last good command
			wire snap_en = !ctrl_stop && !comm_fail_in;
			logic [15:0] last_reg;
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					last_reg <= 16'h0;
				end else if (snap_en) begin
					last_reg <= process_value_in[ch];
				end
			end

			// target selection: substitute or process value clipped to full scale, or the unclipped held value
			// a communication failure takes the same reaction as a controller stop
			wire in_stop = ctrl_stop || comm_fail_in;
			// overrange commands are clipped here and, with phase_control_mode_in set, flagged by the diagnostic
			wire pv_over = (process_value_in[ch] > PV_FULL);
			wire [15:0] pv_clip = pv_over ? PV_FULL : process_value_in[ch];
			// a substitute value beyond full scale is clipped the same way
			wire subst_over = (cfg.subst_value > PV_FULL);
			wire [15:0] subst_clip = subst_over ? PV_FULL : cfg.subst_value;
			// stop reaction decode; turn-off is the fallback for any other code
			wire react_subst = (cfg.stop_react == STOP_SUBST);
			wire react_keep = (cfg.stop_react == STOP_KEEP);
			wire [15:0] keep_val = react_keep ? last_reg : 16'h0;
			wire [15:0] stop_val = react_subst ? subst_clip : keep_val; // RL13
			// stop values pass through the same filter as process values
			wire [15:0] cmd_val = in_stop ? stop_val : pv_clip; // RL11
			// off forces zero target and zero drive at once; the ramp does not shape the turn-off
			wire blocked = !cfg.active || shut_reg; // RL16 RL1
			wire [15:0] target = blocked ? 16'h0 : cmd_val;

			// linear ramp filter with fractional accumulator
			logic [ACC_W-1:0] acc_reg;
			logic [ACC_W-1:0] acc_next;
			wire [ACC_W-1:0] tgt_acc = {target, FRAC_W'(0)};
			wire rising = tgt_acc > acc_reg;
			wire [ACC_W-1:0] step_up = ramp_step(cfg.filt_up); // RL9 RL20
			wire [ACC_W-1:0] step_dn = ramp_step(cfg.filt_down); // RL9 RL20
			wire [ACC_W-1:0] gap_up = tgt_acc - acc_reg;
			wire [ACC_W-1:0] gap_dn = acc_reg - tgt_acc;
			wire [ACC_W-1:0] gap = rising ? gap_up : gap_dn;
			// jump straight to target when unfiltered or within one step of it,
			// which is what stops the ramp from overshooting
			wire up_direct = (cfg.filt_up == FLT_NONE) || (gap <= step_up);
			wire dn_direct = (cfg.filt_down == FLT_NONE) || (gap <= step_dn);
			// sums prepared here; the down sum only used when gap exceeds the step
			wire [ACC_W-1:0] acc_up = acc_reg + step_up;
			wire [ACC_W-1:0] acc_dn = acc_reg - step_dn;
			// hold during delay, otherwise one step per tick towards the target
			always_comb begin
				acc_next = acc_reg;
				if (delaying) begin
					acc_next = acc_reg; // RL7
				end else if (rising) begin
					if (up_direct) begin
						acc_next = tgt_acc; // RL12 RL20
					end else if (tick_reg) begin
						acc_next = acc_up; // RL8 RL6
					end
				end else begin
					if (dn_direct) begin
						acc_next = tgt_acc; // RL12 RL20
					end else if (tick_reg) begin
						acc_next = acc_dn; // RL6 RL11
					end
				end
			end
			// accumulator keeps its value across a delay so the ramp resumes there
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					acc_reg <= '0;
				end else begin
					acc_reg <= acc_next; // RL10
				end
			end

			// drive and status registers
			wire off_now = blocked || delaying; // RL21 RL4
			wire [15:0] drive_next = off_now ? 16'h0 : acc_reg[ACC_W-1:FRAC_W];
			// value counts as present only once the ramp has settled on the command
			wire wire_open = open_sync_reg[ch];
			wire [15:0] acc_int = acc_reg[ACC_W-1:FRAC_W];
			wire settled = (acc_int == cmd_val);
			wire present = !off_now && !wire_open && settled && !pv_over;
			// overflow and wire-break diagnostics raise only when their enable is set; overtemperature has no enable
			wire ovf_flag = phase_control_mode_in && cfg.diag_overflow_en && pv_over; // RL17 RL19
			wire wb_flag = cfg.diag_wire_break_en && wire_open; // RL18
			chan_stat_s stat_next;
			always_comb begin
				stat_next.value_status = vs_enable && present; // RL14
				stat_next.diag_overflow = ovf_flag; // RL17
				stat_next.diag_wire_break = wb_flag; // RL18
				stat_next.diag_overtemp = over_temp;
				stat_next.delay_running = delaying;
			end
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					drive_level_out[ch] <= 16'h0;
					status_out[ch] <= '0;
				end else begin
					drive_level_out[ch] <= drive_next;
					status_out[ch] <= stat_next;
				end
			end
		end
	endgenerate
endmodule

/* tb/ac_out_asserts.sv */
`timescale 1ns/1ps
module ac_out_asserts #(
	parameter int unsigned CHANNELS = 4
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire ac_out_pkg::chan_cfg_s [CHANNELS-1:0] cfg_in,
	input wire logic over_temp_in,
	input wire logic [CHANNELS-1:0][15:0] drive_level_out,
	input wire ac_out_pkg::chan_stat_s [CHANNELS-1:0] status_out
);
	import ac_out_pkg::*;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// channel 0 stands for all in the assertions, the delay cover watches channel 2; the others share the same logic
	wire logic [15:0] lvl = drive_level_out[0];
	wire chan_stat_s st = status_out[0];
	property p_off; !cfg_in[0].active |=> lvl == 16'h0000; endproperty
	a_off: assert property (p_off) else $error("inactive channel driven");
	property p_dly; st.delay_running |-> lvl == 16'h0000; endproperty
	a_dly: assert property (p_dly) else $error("driven during delay");
	property p_max; lvl <= PV_FULL; endproperty
	a_max: assert property (p_max) else $error("level above full scale");
	property p_ovf; (!cfg_in[0].diag_overflow_en)[*2] |-> !st.diag_overflow; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow while disabled");
	property p_wb; (!cfg_in[0].diag_wire_break_en)[*2] |-> !st.diag_wire_break; endproperty
	a_wb: assert property (p_wb) else $error("wire break while disabled");
	property p_vs; st.value_status |-> !st.delay_running; endproperty
	a_vs: assert property (p_vs) else $error("value good during delay");
	// fastest filter (500 ms): at most one unit up per cycle, delay end excluded
	property p_ramp;
		cfg_in[0].filt_up == FLT_500MS && $past(cfg_in[0].filt_up) == FLT_500MS
			&& !$past(st.delay_running) |-> lvl <= $past(lvl) + 16'h0001;
	endproperty
	a_ramp: assert property (p_ramp) else $error("rising step too steep");
	property p_hot; (over_temp_in && cfg_in[0].temp_shutdown)[*5] |-> lvl == 16'h0000; endproperty
	a_hot: assert property (p_hot) else $error("driven while overheated");
	c_dly: cover property (status_out[2].delay_running);
	c_ovf: cover property (st.diag_overflow);
	c_vs: cover property (st.value_status);
endmodule
bind ac_output_channel_control ac_out_asserts #(.CHANNELS(CHANNELS)) ac_out_asserts_inst (
	.mclk_in(mclk_in),
	.rst_in(rst_in),
	.cfg_in(cfg_in),
	.over_temp_in(over_temp_in),
	.drive_level_out(drive_level_out),
	.status_out(status_out)
);

/* tb/plc_model.sv */
`timescale 1ns/1ps
module plc_model #(
	parameter int unsigned CHANNELS = 4
) (
	input wire logic mclk_in,
	output logic [CHANNELS-1:0][15:0] process_value_out,
	output logic stop_out
);
	import ac_out_pkg::*;
	// controller running with an all-zero process image
	initial begin
		process_value_out = '0;
		stop_out = 1'b0;
	end
	// overrange only when a test asks for it on purpose
	task automatic write_pv(input int ch, input logic [15:0] v, input bit over);
		@(posedge mclk_in);
		process_value_out[ch] <= (over || v <= PV_FULL) ? v : PV_FULL;
	endtask
	task automatic set_stop(input logic s);
		@(posedge mclk_in);
		stop_out <= s;
	endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import ac_out_pkg::*;
	localparam int unsigned CH = 4;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	chan_cfg_s [CH-1:0] cfg;
	logic [CH-1:0][15:0] pv;
	logic [CH-1:0][15:0] lvl;
	chan_stat_s [CH-1:0] st;
	logic stop;
	logic hot = 1'b0;
	logic load_ok = 1'b1;
	logic [CH-1:0] open_w = '0;
	logic comm_fail = 1'b0;
	logic qi = 1'b0;
	logic vs_en = 1'b1;
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	always #10 mclk_in = ~mclk_in;
	plc_model #(.CHANNELS(CH)) plc_model_inst (
		.mclk_in(mclk_in),
		.process_value_out(pv),
		.stop_out(stop)
	);
	// fast tick keeps the long delays and ramps short
	ac_output_channel_control #(.CHANNELS(CH), .TICK_DIV(2)) ac_output_channel_control_inst (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.cfg_in(cfg),
		.process_value_in(pv),
		.controller_stop_in(stop),
		.comm_fail_in(comm_fail),
		.quality_information_bits_in(qi),
		.value_status_en_in(vs_en),
		.phase_control_mode_in(1'b1),
		.over_temp_in(hot),
		.load_voltage_ok_in(load_ok),
		.wire_open_in(open_w),
		.drive_level_out(lvl),
		.status_out(st)
	);
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t level %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard, well above the few thousand cycles the tests need
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		cfg = '0;
		for (int i = 0; i < CH; i++) cfg[i].active = 1'b1;
		cyc(8);
		rst_in <= 1'b0;
		cyc(2);
		// direct pass and a deactivated neighbour
		cfg[1].active <= 1'b0;
		plc_model_inst.write_pv(0, 16'h01f4, 1'b0);
		plc_model_inst.write_pv(1, 16'h02bc, 1'b0);
		cyc(4);
		chk16(lvl[0], 16'h01f4);
		chk16(lvl[1], 16'h0000);
		chk1(st[0].value_status, 1'b1);
		// status off when disabled, forced on by the quality variant
		vs_en <= 1'b0;
		cyc(2);
		chk1(st[0].value_status, 1'b0);
		qi <= 1'b1;
		cyc(2);
		chk1(st[0].value_status, 1'b1);
		qi <= 1'b0;
		vs_en <= 1'b1;
		// overrange is clipped and flagged
		cfg[0].diag_overflow_en <= 1'b1;
		plc_model_inst.write_pv(0, 16'h04b0, 1'b1);
		cyc(4);
		chk16(lvl[0], PV_FULL);
		chk1(st[0].diag_overflow, 1'b1);
		plc_model_inst.write_pv(0, 16'h012c, 1'b0);
		// open load reported only once enabled
		open_w[0] <= 1'b1;
		cyc(5);
		chk1(st[0].diag_wire_break, 1'b0);
		cfg[0].diag_wire_break_en <= 1'b1;
		cyc(3);
		chk1(st[0].diag_wire_break, 1'b1);
		chk1(st[0].value_status, 1'b0);
		open_w[0] <= 1'b0;
		// shutdown ignores new values until cool again
		cfg[0].temp_shutdown <= 1'b1;
		hot <= 1'b1;
		cyc(5);
		chk16(lvl[0], 16'h0000);
		chk1(st[0].diag_overtemp, 1'b1);
		plc_model_inst.write_pv(0, 16'h00c8, 1'b0);
		cyc(5);
		chk16(lvl[0], 16'h0000);
		hot <= 1'b0;
		cyc(6);
		chk16(lvl[0], 16'h00c8);
		// substitute value on stop, ramped down then back up
		cfg[0].filt_down <= FLT_500MS;
		cfg[0].filt_up <= FLT_500MS;
		cfg[0].stop_react <= STOP_SUBST;
		cfg[0].subst_value <= 16'h0064;
		plc_model_inst.set_stop(1'b1);
		cyc(200);
		chk1(lvl[0] >= 16'h00aa && lvl[0] <= 16'h00be, 1'b1);
		cyc(1000);
		chk16(lvl[0], 16'h0064);
		plc_model_inst.set_stop(1'b0);
		cyc(1100);
		chk16(lvl[0], 16'h00c8);
		// startup delay restarts on load return
		cfg[2].start_dly <= DLY_100MS;
		plc_model_inst.write_pv(2, 16'h0190, 1'b0);
		load_ok <= 1'b0;
		cyc(5);
		chk16(lvl[2], 16'h0000);
		load_ok <= 1'b1;
		cyc(1900);
		chk16(lvl[2], 16'h0000);
		chk1(st[2].delay_running, 1'b1);
		cyc(200);
		chk16(lvl[2], 16'h0190);
		// communication failure takes the stop reaction, here turn-off
		plc_model_inst.write_pv(3, 16'h0100, 1'b0);
		cyc(3);
		chk16(lvl[3], 16'h0100);
		comm_fail <= 1'b1;
		cyc(3);
		chk16(lvl[3], 16'h0000);
		comm_fail <= 1'b0;
		cyc(3);
		chk16(lvl[3], 16'h0100);
		complete_run();
	end
endmodule
